// ---- verilog/alu_pkg.sv ----
// Constants and types shared by the rotate, subtract and skip datapath.
// Assumes a single 125 MHz core clock and an 8-bit data memory byte.
package alu_pkg;

  // ****************************************************************
  // Data width and fixed byte values
  // ****************************************************************
  localparam int        BYTE_W     = 8;       // Width of memory and accumulator bytes.
  localparam logic [7:0] BYTE_ONES = 8'hFF;   // Value written by the set-byte operation.
  localparam logic [7:0] BYTE_ZERO = 8'h00;   // Zero value for compares.
  localparam logic [7:0] BYTE_ONE  = 8'h01;   // Step for increment and decrement.

  // ****************************************************************
  // Register port map
  // ****************************************************************
  localparam logic [1:0] ADDR_ACCUMULATOR = 2'h0;  // Accumulator, read and write.
  localparam logic [1:0] ADDR_STATUS      = 2'h1;  // Flags and interrupt enable.

  // Bit positions inside the status register.
  localparam int BIT_CARRY = 0;
  localparam int BIT_AUX   = 1;
  localparam int BIT_ZERO  = 2;
  localparam int BIT_OVF   = 3;
  localparam int BIT_SCMP  = 4;
  localparam int BIT_CZERO = 5;
  localparam int BIT_MIE   = 6;

  // Reset values.
  localparam logic [7:0] RESET_ACCUMULATOR = 8'h00;
  localparam logic [6:0] RESET_STATUS      = 7'h00;

  // ****************************************************************
  // Operation codes presented by the instruction decoder
  // ****************************************************************
  typedef enum logic [4:0] {
    op_idle,
    op_rotate_left_carry_to_acc,
    op_rotate_right_mem,
    op_rotate_right_to_acc,
    op_rotate_right_carry_mem,
    op_rotate_right_carry_to_acc,
    op_subtract_with_borrow,
    op_subtract_with_borrow_to_mem,
    op_subtract_plain,
    op_subtract_to_mem,
    op_decrement_skip_zero,
    op_decrement_to_acc_skip_zero,
    op_increment_skip_zero,
    op_increment_to_acc_skip_zero,
    op_set_byte,
    op_set_bit,
    op_skip_if_bit_nonzero,
    op_skip_if_nonzero,
    op_nibble_exchange_mem,
    op_nibble_exchange_to_acc,
    op_return_from_interrupt
  } op_t;

endpackage : alu_pkg

// ---- verilog/sub_if.sv ----
// Interface between the datapath and its subtractor unit.
// Assumes both ends sit in the same clock domain; it is purely combinational.
`timescale 1ns/1ns
`default_nettype none
interface sub_if;
  logic [7:0] a;      // Minuend, the accumulator.
  logic [7:0] b;      // Subtrahend, memory byte or immediate.
  logic       cin;    // Carry in; low means one extra borrow.
  logic [7:0] diff;   // Eight-bit difference.
  logic       cout;   // Inverted borrow out of bit 7.
  logic       aux;    // Inverted borrow out of bit 3.
  logic       ovf;    // Signed overflow.
  logic       zero;   // Difference is zero.

  modport unit (input a, b, cin, output diff, cout, aux, ovf, zero);
  modport user (output a, b, cin, input diff, cout, aux, ovf, zero);
endinterface : sub_if
`default_nettype wire

// ---- verilog/sub_unit.sv ----
// Eight-bit subtractor with carry-as-inverted-borrow flag outputs.
// Assumes operands arrive stable from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module sub_unit (
  sub_if.unit s
);
  // ****************************************************************
  // Arithmetic
  // ****************************************************************
  logic [8:0] full_w;  // Nine-bit difference, top bit is the borrow.
  logic [4:0] low_w;   // Low nibble difference, top bit is the borrow.

  // A clear carry costs one more unit of borrow.
  assign full_w = {1'b0, s.a} - {1'b0, s.b} - {8'h00, ~s.cin};
  assign low_w  = {1'b0, s.a[3:0]} - {1'b0, s.b[3:0]} - {4'h0, ~s.cin};

  assign s.diff = full_w[7:0];
  assign s.cout = ~full_w[8];  // Negative clears carry.
  assign s.aux  = ~low_w[4];   // Borrow into bit 4, inverted.
  assign s.ovf  = (s.a[7] ^ s.b[7]) & (s.a[7] ^ full_w[7]);
  assign s.zero = (full_w[7:0] == 8'h00);
endmodule : sub_unit
`default_nettype wire

// ---- verilog/bit_unit.sv ----
// Rotate, nibble swap, set and step logic on one memory byte.
// Assumes the operation code and byte come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module bit_unit
  import alu_pkg::*;
(
  input  wire op_t        op,         // Operation in progress.
  input  wire logic [7:0] data_in,    // Addressed memory byte.
  input  wire logic       carry_in,   // Present carry flag.
  input  wire logic [2:0] bit_sel,    // Selected bit number.
  output logic      [7:0] data_out,   // Byte result.
  output logic            carry_out   // Carry produced by through-carry rotates.
);
  // ****************************************************************
  // Byte operations
  // ****************************************************************
  // One combinational case keeps all byte shuffles in one place.
  always_comb begin
    data_out  = data_in;
    carry_out = carry_in;
    case (op)
      op_rotate_left_carry_to_acc: begin
        data_out  = {data_in[6:0], carry_in};
        carry_out = data_in[7];
      end
      op_rotate_right_mem, op_rotate_right_to_acc: begin
        data_out = {data_in[0], data_in[7:1]};
      end
      op_rotate_right_carry_mem, op_rotate_right_carry_to_acc: begin
        data_out  = {carry_in, data_in[7:1]};
        carry_out = data_in[0];
      end
      op_decrement_skip_zero, op_decrement_to_acc_skip_zero: begin
        data_out = data_in - BYTE_ONE;
      end
      op_increment_skip_zero, op_increment_to_acc_skip_zero: begin
        data_out = data_in + BYTE_ONE;
      end
      op_set_byte: begin
        data_out = BYTE_ONES;
      end
      op_set_bit: begin
        data_out = data_in | (BYTE_ONE << bit_sel);
      end
      op_nibble_exchange_mem, op_nibble_exchange_to_acc: begin
        data_out = {data_in[3:0], data_in[7:4]};
      end
      default: begin
        data_out = data_in;
      end
    endcase
  end
endmodule : bit_unit
`default_nettype wire

// ---- verilog/rotate_subtract_skip_alu.sv ----
// Execution datapath for rotates, subtracts, set, swap and skip operations.
// Assumes the decoder presents one operation with its memory byte in the same
// cycle, on the same clock, and honours the skip and dummy-cycle outputs.
`timescale 1ns/1ns
`default_nettype none
module rotate_subtract_skip_alu
  import alu_pkg::*;
(
  input  wire logic       clk,            // Core clock, 125 MHz.
  input  wire logic       rst,            // Asynchronous reset, active high.
  input  wire logic       ce,             // Clock enable; low freezes all state.
  input  wire logic       op_valid,       // Decoder presents an operation.
  input  wire op_t        op_code,        // Operation to perform.
  input  wire logic       use_imm,        // Subtract takes the immediate byte.
  input  wire logic [7:0] imm_data,       // Immediate operand.
  input  wire logic [7:0] mem_rdata,      // Addressed data memory byte.
  input  wire logic [2:0] bit_sel,        // Bit number for bit operations.
  input  wire logic       mie_clear,      // Interrupt entry clears the enable.
  input  wire logic [1:0] reg_addr,       // Register port address.
  input  wire logic [7:0] reg_wdata,      // Register port write data.
  input  wire logic       reg_wr,         // Register write strobe.
  input  wire logic       reg_rd,         // Register read strobe.
  output logic      [7:0] reg_rdata_q,    // Read data, one cycle after strobe.
  output logic      [7:0] accumulator_q,  // Accumulator.
  output logic      [6:0] status_q,       // Flags and interrupt enable.
  output logic            mem_wr_q,       // Write-back strobe to data memory.
  output logic      [7:0] mem_wdata_q,    // Write-back byte.
  output logic            skip_q,         // Dummy cycle of a taken skip.
  output logic            done_q          // Operation finished.
);

  // ****************************************************************
  // Operation classes
  // ****************************************************************
  logic take_w;          // Operation accepted at this edge.
  logic is_borrow_sub_w; // Subtract that consumes the carry.
  logic is_sub_w;        // Any subtract.
  logic sub_to_mem_w;    // Subtract with memory destination.
  logic bit_to_mem_w;    // Byte operation with memory destination.
  logic bit_to_acc_w;    // Byte operation with accumulator destination.
  logic rot_carry_w;     // Rotate through carry.
  logic step_w;          // Increment or decrement with skip.

  // A dummy cycle refuses new work so the skipped fetch is discarded.
  assign take_w = ce & op_valid & ~skip_q & (op_code != op_idle);

  assign is_borrow_sub_w = (op_code == op_subtract_with_borrow)
                         | (op_code == op_subtract_with_borrow_to_mem);
  assign is_sub_w        = is_borrow_sub_w
                         | (op_code == op_subtract_plain)
                         | (op_code == op_subtract_to_mem);
  assign sub_to_mem_w    = (op_code == op_subtract_with_borrow_to_mem)
                         | (op_code == op_subtract_to_mem);
  assign bit_to_mem_w    = (op_code == op_rotate_right_mem)
                         | (op_code == op_rotate_right_carry_mem)
                         | (op_code == op_decrement_skip_zero)
                         | (op_code == op_increment_skip_zero)
                         | (op_code == op_set_byte)
                         | (op_code == op_set_bit)
                         | (op_code == op_skip_if_nonzero)
                         | (op_code == op_nibble_exchange_mem);
  assign bit_to_acc_w    = (op_code == op_rotate_left_carry_to_acc)
                         | (op_code == op_rotate_right_to_acc)
                         | (op_code == op_rotate_right_carry_to_acc)
                         | (op_code == op_decrement_to_acc_skip_zero)
                         | (op_code == op_increment_to_acc_skip_zero)
                         | (op_code == op_nibble_exchange_to_acc);
  assign rot_carry_w     = (op_code == op_rotate_left_carry_to_acc)
                         | (op_code == op_rotate_right_carry_mem)
                         | (op_code == op_rotate_right_carry_to_acc);
  assign step_w          = (op_code == op_decrement_skip_zero)
                         | (op_code == op_decrement_to_acc_skip_zero)
                         | (op_code == op_increment_skip_zero)
                         | (op_code == op_increment_to_acc_skip_zero);

  // ****************************************************************
  // Arithmetic units
  // ****************************************************************
  sub_if sub ();  // Subtractor connection.

  logic [7:0] bit_res_w;    // Byte unit result.
  logic       bit_carry_w;  // Byte unit carry.

  // Plain subtract forces carry in high so no extra borrow is taken.
  assign sub.a   = accumulator_q;
  assign sub.b   = use_imm ? imm_data : mem_rdata;
  assign sub.cin = is_borrow_sub_w ? status_q[BIT_CARRY] : 1'b1;

  sub_unit u_sub (
    .s (sub.unit)
  );

  bit_unit u_bit (
    .op        (op_code),
    .data_in   (mem_rdata),
    .carry_in  (status_q[BIT_CARRY]),
    .bit_sel   (bit_sel),
    .data_out  (bit_res_w),
    .carry_out (bit_carry_w)
  );

  // ****************************************************************
  // Skip decision
  // ****************************************************************
  logic skip_cond_w;  // Skip condition of the current operation.
  logic mem_write_w;  // Current operation writes memory.

  assign skip_cond_w =
      (step_w & (bit_res_w == BYTE_ZERO))
    | ((op_code == op_skip_if_nonzero) & (mem_rdata != BYTE_ZERO))
    | ((op_code == op_skip_if_bit_nonzero) & mem_rdata[bit_sel]);

  assign mem_write_w = bit_to_mem_w | sub_to_mem_w;

  // ****************************************************************
  // Next accumulator and status
  // ****************************************************************
  logic       acc_wr_w;     // Register port writes the accumulator.
  logic       stat_wr_w;    // Register port writes the status.
  logic [7:0] acc_d;        // Next accumulator.
  logic [6:0] status_d;     // Next status.
  logic [6:0] stat_base_w;  // Status before operation effects.
  logic [6:0] sub_flags_w;  // Status after a subtract.
  logic       cz_w;         // Chained zero for this subtract.
  logic       mie_w;        // Next interrupt enable.

  assign acc_wr_w  = ce & reg_wr & (reg_addr == ADDR_ACCUMULATOR);
  assign stat_wr_w = ce & reg_wr & (reg_addr == ADDR_STATUS);

  // An operation in the same cycle wins over a software register write.
  assign acc_d =
      (take_w & is_sub_w & ~sub_to_mem_w) ? sub.diff :
      (take_w & bit_to_acc_w)             ? bit_res_w :
      acc_wr_w                            ? reg_wdata :
                                            accumulator_q;

  assign stat_base_w = stat_wr_w ? reg_wdata[6:0] : status_q;

  // Chained zero keeps the zero of earlier bytes for multi-byte borrows.
  assign cz_w = is_borrow_sub_w ? (sub.zero & status_q[BIT_CZERO]) : sub.zero;

  always_comb begin
    sub_flags_w            = status_q;
    sub_flags_w[BIT_CARRY] = sub.cout;
    sub_flags_w[BIT_AUX]   = sub.aux;
    sub_flags_w[BIT_ZERO]  = sub.zero;
    sub_flags_w[BIT_OVF]   = sub.ovf;
    sub_flags_w[BIT_SCMP]  = ~(sub.diff[7] ^ sub.ovf);
    sub_flags_w[BIT_CZERO] = cz_w;
  end

  // Return from interrupt sets the enable and wins over a same-cycle clear.
  assign mie_w = (take_w & (op_code == op_return_from_interrupt)) ? 1'b1 :
                 (ce & mie_clear)                                 ? 1'b0 :
                                                                    stat_base_w[BIT_MIE];

  always_comb begin
    if (take_w & is_sub_w) begin
      status_d = sub_flags_w;
    end else if (take_w & rot_carry_w) begin
      status_d = status_q;
      status_d[BIT_CARRY] = bit_carry_w;  // Only carry moves.
    end else begin
      status_d = stat_base_w;  // Other operations leave flags alone.
    end
    status_d[BIT_MIE] = mie_w;
  end

  // ****************************************************************
  // Register read mux
  // ****************************************************************
  logic [7:0] rdata_d;  // Next read data.

  // Unmapped addresses read as zero.
  assign rdata_d = (reg_addr == ADDR_ACCUMULATOR) ? accumulator_q :
                   (reg_addr == ADDR_STATUS)      ? {1'b0, status_q} :
                                                    BYTE_ZERO;

  // ****************************************************************
  // State registers
  // ****************************************************************
  // Accumulator and status; ce low leaves them frozen.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      accumulator_q <= RESET_ACCUMULATOR;
      status_q      <= RESET_STATUS;
    end else if (ce) begin
      accumulator_q <= acc_d;
      status_q      <= status_d;
    end
  end

  // Memory write-back strobe and data, one cycle after the operation.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_wr_q    <= 1'b0;
      mem_wdata_q <= BYTE_ZERO;
    end else if (ce) begin
      mem_wr_q    <= take_w & mem_write_w;
      mem_wdata_q <= sub_to_mem_w ? sub.diff : bit_res_w;
    end
  end

  // Skip marks the dummy cycle; it lasts exactly one enabled cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      skip_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      skip_q <= take_w & skip_cond_w;
      done_q <= take_w;
    end
  end

  // Read data stands in the cycle after the strobe only.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= BYTE_ZERO;
    end else if (ce) begin
      reg_rdata_q <= reg_rd ? rdata_d : BYTE_ZERO;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_rlc_to_acc: assert property (
    take_w && op_code == op_rotate_left_carry_to_acc |=>
      accumulator_q == {$past(mem_rdata[6:0]), $past(status_q[BIT_CARRY])}
      && status_q[BIT_CARRY] == $past(mem_rdata[7]) && !mem_wr_q)
    else $error("left rotate through carry wrong");

  a_rr_mem_flags: assert property (
    take_w && op_code == op_rotate_right_mem && !reg_wr |=>
      mem_wr_q && mem_wdata_q == {$past(mem_rdata[0]), $past(mem_rdata[7:1])}
      && status_q == $past(status_q))
    else $error("plain right rotate wrong");

  a_rrc_carry: assert property (
    take_w && op_code == op_rotate_right_carry_to_acc |=>
      accumulator_q[7] == $past(status_q[BIT_CARRY])
      && status_q[BIT_CARRY] == $past(mem_rdata[0]))
    else $error("right rotate through carry wrong");

  a_sbc_result: assert property (
    take_w && op_code == op_subtract_with_borrow |=>
      accumulator_q == 8'($past(accumulator_q) - $past(sub.b)
                          - {7'h00, ~$past(status_q[BIT_CARRY])}))
    else $error("borrow subtract result wrong");

  a_subtract_with_borrow_to_mem_keep_acc: assert property (
    take_w && op_code == op_subtract_with_borrow_to_mem && !reg_wr |=>
      mem_wr_q && accumulator_q == $past(accumulator_q))
    else $error("memory subtract touched accumulator");

  a_sub_carry: assert property (
    take_w && is_sub_w |=>
      status_q[BIT_CARRY] == ({1'b0, $past(accumulator_q)} >= {1'b0, $past(sub.b)}
                              + {8'h00, $past(is_borrow_sub_w & ~status_q[BIT_CARRY])}))
    else $error("subtract carry is not inverted borrow");

  a_sub_zero: assert property (
    take_w && op_code == op_subtract_plain && !use_imm && accumulator_q == mem_rdata |=>
      status_q[BIT_ZERO] && status_q[BIT_CARRY] && accumulator_q == BYTE_ZERO)
    else $error("equal subtract flags wrong");

  a_step_skip: assert property (
    take_w && op_code == op_decrement_skip_zero |=>
      skip_q == ($past(mem_rdata) == BYTE_ONE) && mem_wdata_q == 8'($past(mem_rdata) - 8'h01))
    else $error("decrement skip wrong");

  a_dec_acc_skip: assert property (
    take_w && op_code == op_decrement_to_acc_skip_zero |=>
      accumulator_q == 8'($past(mem_rdata) - 8'h01) && !mem_wr_q
      && skip_q == ($past(mem_rdata) == BYTE_ONE))
    else $error("decrement into accumulator wrong");

  a_inc_mem_skip: assert property (
    take_w && op_code == op_increment_skip_zero |=>
      mem_wr_q && mem_wdata_q == 8'($past(mem_rdata) + 8'h01)
      && skip_q == ($past(mem_rdata) == BYTE_ONES))
    else $error("increment skip wrong");

  a_inc_acc_skip: assert property (
    take_w && op_code == op_increment_to_acc_skip_zero |=>
      accumulator_q == 8'($past(mem_rdata) + 8'h01) && !mem_wr_q
      && skip_q == ($past(mem_rdata) == BYTE_ONES))
    else $error("increment into accumulator wrong");

  a_set_bit: assert property (
    take_w && op_code == op_set_bit |=>
      mem_wr_q && mem_wdata_q == ($past(mem_rdata) | (BYTE_ONE << $past(bit_sel))))
    else $error("set bit wrong");

  a_bit_test_skip: assert property (
    take_w && op_code == op_skip_if_bit_nonzero |=>
      skip_q == $past(mem_rdata[bit_sel]) && !mem_wr_q)
    else $error("bit test skip wrong");

  a_byte_test_skip: assert property (
    take_w && op_code == op_skip_if_nonzero |=>
      mem_wr_q && mem_wdata_q == $past(mem_rdata)
      && skip_q == ($past(mem_rdata) != BYTE_ZERO))
    else $error("byte test skip wrong");

  a_swap_mem: assert property (
    take_w && op_code == op_nibble_exchange_mem |=>
      mem_wr_q && mem_wdata_q == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})
    else $error("nibble swap in memory wrong");

  a_skip_one_cycle: assert property (
    skip_q && ce |=> !skip_q && !done_q)
    else $error("dummy cycle not exactly one");

  a_set_byte: assert property (
    take_w && op_code == op_set_byte |=> mem_wr_q && mem_wdata_q == BYTE_ONES)
    else $error("set byte wrong");

  a_swap_acc: assert property (
    take_w && op_code == op_nibble_exchange_to_acc |=>
      accumulator_q == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])} && !mem_wr_q)
    else $error("nibble swap to accumulator wrong");

  a_reti_mie: assert property (
    take_w && op_code == op_return_from_interrupt |=> status_q[BIT_MIE])
    else $error("interrupt return did not set enable");

  c_skip_taken:  cover property (take_w && skip_cond_w ##1 skip_q);
  c_sub_to_mem:  cover property (take_w && op_code == op_subtract_to_mem ##1 mem_wr_q);
  c_bit_test:    cover property (take_w && op_code == op_skip_if_bit_nonzero && skip_cond_w);
  c_reg_readout: cover property (reg_rd && reg_addr == ADDR_STATUS ##1 reg_rdata_q != 8'h00);

endmodule : rotate_subtract_skip_alu
`default_nettype wire

// ---- dv/mem_byte_model.sv ----
// Memory byte model that stands behind the datapath's operation port.
// Assumes the bench preloads the byte before each operation.
`timescale 1ns/1ns
`default_nettype none
module mem_byte_model (
  input  wire logic       clk,     // Core clock.
  input  wire logic       rst,     // Asynchronous reset.
  input  wire logic       ld,      // Bench preload strobe.
  input  wire logic [7:0] ld_v,    // Byte to preload.
  input  wire logic       wr,      // Write-back strobe.
  input  wire logic [7:0] wd,      // Write-back byte.
  output logic      [7:0] rdata_q  // Addressed byte.
);
  // A preload wins, so every scenario starts from a known byte.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (ld) begin
      rdata_q <= ld_v;
    end else if (wr) begin
      rdata_q <= wd;
    end
  end
endmodule  // mem_byte_model
`default_nettype wire

// ---- dv/rotate_subtract_skip_alu_tb_top.sv ----
// Self-checking bench for the rotate, subtract and skip datapath.
// Assumes the memory byte model sits on the operation port.
`timescale 1ns/1ns
`default_nettype none
module rotate_subtract_skip_alu_tb_top import alu_pkg::*;;
  logic clk, rst, ce, op_valid, use_imm, mie_clear, reg_wr, reg_rd, ld, mw, sk, dn;
  op_t op_code;
  logic [7:0] imm_data, mem_rdata, reg_wdata, reg_rdata_q, acc, wd, ld_v;
  logic [2:0] bit_sel;
  logic [1:0] reg_addr;
  logic [6:0] st;
  int num_errors = 0;
  int cmp_count = 0;
  rotate_subtract_skip_alu uut (.clk(clk), .rst(rst), .ce(ce), .op_valid(op_valid),
    .op_code(op_code), .use_imm(use_imm), .imm_data(imm_data), .mem_rdata(mem_rdata),
    .bit_sel(bit_sel), .mie_clear(mie_clear), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .accumulator_q(acc),
    .status_q(st), .mem_wr_q(mw), .mem_wdata_q(wd), .skip_q(sk), .done_q(dn));
  mem_byte_model mem_model (.clk(clk), .rst(rst), .ld(ld), .ld_v(ld_v), .wr(mw),
    .wd(wd), .rdata_q(mem_rdata));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Preload, offer one op, then judge the answer one cycle later.
  task automatic run(input op_t o, input logic [7:0] m, a, w, input logic [2:0] f);
    @(posedge clk) ld <= 1'b1;
    ld_v <= m;
    @(posedge clk) ld <= 1'b0;
    op_valid <= 1'b1;
    op_code <= o;
    @(posedge clk) op_valid <= 1'b0;
    #1 chk("acc", acc, a);
    chk("done_wr_skip", {5'h0, dn, mw, sk}, {5'h0, f});
    if (f[1]) chk("wdata", wd, w);
  endtask
  task automatic reg_write(input logic [1:0] ad, input logic [7:0] d);
    @(posedge clk) reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [1:0] ad, input logic [7:0] e);
    @(posedge clk) reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk) reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata_q, e);
  endtask
  task automatic rotates;
    reg_write(ADDR_STATUS, 8'h01);
    run(op_rotate_left_carry_to_acc, 8'h81, 8'h03, 8'h00, 3'b100);
    chk("carry", {7'h0, st[BIT_CARRY]}, 8'h01);
    run(op_rotate_right_to_acc, 8'h81, 8'hC0, 8'h00, 3'b100);
    run(op_rotate_right_mem, 8'h81, 8'hC0, 8'hC0, 3'b110);
    run(op_rotate_right_carry_to_acc, 8'h02, 8'h81, 8'h00, 3'b100);
    chk("carry", {7'h0, st[BIT_CARRY]}, 8'h00);
    run(op_rotate_right_carry_mem, 8'h03, 8'h81, 8'h01, 3'b110);
  endtask
  task automatic subtracts;
    reg_write(ADDR_ACCUMULATOR, 8'h05);
    run(op_subtract_plain, 8'h06, 8'hFF, 8'h00, 3'b100);
    chk("status", {4'h0, st[3:0]}, 8'h00);
    @(posedge clk) use_imm <= 1'b1;
    run(op_subtract_with_borrow, 8'h00, 8'hFD, 8'h00, 3'b100);
    chk("status", {4'h0, st[3:0]}, 8'h03);
    @(posedge clk) use_imm <= 1'b0;
    run(op_subtract_to_mem, 8'hFD, 8'hFD, 8'h00, 3'b110);
    chk("status", {4'h0, st[3:0]}, 8'h07);
    run(op_subtract_plain, 8'hFD, 8'h00, 8'h00, 3'b100);
    chk("status", {4'h0, st[3:0]}, 8'h07);
    reg_write(ADDR_ACCUMULATOR, 8'h80);
    run(op_subtract_plain, 8'h01, 8'h7F, 8'h00, 3'b100);
    chk("status", {4'h0, st[3:0]}, 8'h09);
    run(op_subtract_with_borrow_to_mem, 8'h7F, 8'h7F, 8'h00, 3'b110);
  endtask
  task automatic skips;
    run(op_decrement_skip_zero, 8'h01, 8'h7F, 8'h00, 3'b111);
    run(op_decrement_to_acc_skip_zero, 8'h05, 8'h04, 8'h00, 3'b100);
    run(op_increment_skip_zero, 8'hFF, 8'h04, 8'h00, 3'b111);
    run(op_increment_to_acc_skip_zero, 8'hFF, 8'h00, 8'h00, 3'b101);
    // The byte still holds FFh, so this increment skips; the op after it must be dropped.
    @(posedge clk) op_valid <= 1'b1;
    op_code <= op_increment_skip_zero;
    @(posedge clk) op_code <= op_set_byte;
    @(posedge clk) op_valid <= 1'b0;
    #1 chk("dummy", {5'h0, dn, mw, sk}, 8'h00);
  endtask
  task automatic bits;
    run(op_set_byte, 8'h12, 8'h00, 8'hFF, 3'b110);
    @(posedge clk) bit_sel <= 3'h3;
    run(op_set_bit, 8'hF0, 8'h00, 8'hF8, 3'b110);
    run(op_skip_if_bit_nonzero, 8'h08, 8'h00, 8'h00, 3'b101);
    run(op_skip_if_bit_nonzero, 8'hF7, 8'h00, 8'h00, 3'b100);
    run(op_skip_if_nonzero, 8'h00, 8'h00, 8'h00, 3'b110);
    run(op_skip_if_nonzero, 8'h40, 8'h00, 8'h40, 3'b111);
    run(op_nibble_exchange_mem, 8'hA5, 8'h00, 8'h5A, 3'b110);
    run(op_nibble_exchange_to_acc, 8'h3C, 8'hC3, 8'h00, 3'b100);
    chk("status", {4'h0, st[3:0]}, 8'h07);
  endtask
  task automatic returns;
    @(posedge clk) mie_clear <= 1'b1;
    @(posedge clk) mie_clear <= 1'b0;
    run(op_return_from_interrupt, 8'h00, 8'hC3, 8'h00, 3'b100);
    reg_read(ADDR_STATUS, 8'h57);
    // A clear offered while the clock enable is low must be ignored.
    @(posedge clk) ce <= 1'b0;
    mie_clear <= 1'b1;
    @(posedge clk) ce <= 1'b1;
    mie_clear <= 1'b0;
    reg_read(ADDR_STATUS, 8'h57);
    @(posedge clk) mie_clear <= 1'b1;
    @(posedge clk) mie_clear <= 1'b0;
    reg_read(ADDR_STATUS, 8'h17);
    reg_read(ADDR_ACCUMULATOR, 8'hC3);
    reg_read(2'h2, 8'h00);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rst, ce} = 2'b11;
    {op_valid, use_imm, mie_clear, reg_wr, reg_rd, ld} = 6'h0;
    op_code = op_idle;
    {imm_data, reg_wdata, ld_v, bit_sel, reg_addr} = {8'h01, 8'h00, 8'h00, 3'h0, 2'h0};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rotates;
    subtracts;
    skips;
    bits;
    returns;
    wrap_up;
  end
  initial begin
    #100000;
    num_errors++;
    wrap_up;
  end
endmodule  // rotate_subtract_skip_alu_tb_top
`default_nettype wire
